// >>> design/serial_dma_pkg.sv
// Function
// - Receive buffer A next-byte offset, wraps after unload.
// - Receive buffer B next-byte offset, wraps after unload.
// - One offset into active transmit buffer, wraps.
// - Buffer A records offset of first errored byte.
// - Buffer B records offset of first errored byte.
// - First-error offset held despite later errors.
// - Error capture rearmed by reload or receive reset.
// - Status bit high while receive buffer A fills.
package serial_dma_pkg;
   localparam int OFS_W = 13;
   localparam int REG_W = 16;
   localparam int IDX_W = 16;
   // Register indices; byte address on the bus is four times the index.
   localparam logic [IDX_W-1:0] IDX_RX_A_START = 16'h4400;
   localparam logic [IDX_W-1:0] IDX_RX_A_END   = 16'h4402;
   localparam logic [IDX_W-1:0] IDX_RX_B_START = 16'h4404;
   localparam logic [IDX_W-1:0] IDX_RX_B_END   = 16'h4406;
   localparam logic [IDX_W-1:0] IDX_TX_A_START = 16'h4408;
   localparam logic [IDX_W-1:0] IDX_TX_A_END   = 16'h440a;
   localparam logic [IDX_W-1:0] IDX_TX_B_START = 16'h440c;
   localparam logic [IDX_W-1:0] IDX_TX_B_END   = 16'h440e;
   localparam logic [IDX_W-1:0] IDX_RX_A_FILL  = 16'h4410;
   localparam logic [IDX_W-1:0] IDX_RX_B_FILL  = 16'h4412;
   localparam logic [IDX_W-1:0] IDX_TX_OFS     = 16'h4414;
   localparam logic [IDX_W-1:0] IDX_STATUS     = 16'h4416;
   localparam logic [IDX_W-1:0] IDX_RX_A_ERR   = 16'h441a;
   localparam logic [IDX_W-1:0] IDX_RX_B_ERR   = 16'h441c;
   localparam logic [IDX_W-1:0] IDX_CTRL       = 16'h4430;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT   = 16'h4432;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 16'h4434;
   // Buffer numbering, shared by load bits, status bits and events.
   localparam int BUF_RX_A = 0;
   localparam int BUF_RX_B = 1;
   localparam int BUF_TX_A = 2;
   localparam int BUF_TX_B = 3;
   localparam int NBUF     = 4;
   localparam int CTRL_RX_RST = 4;
   localparam int CTRL_TX_RST = 5;
   localparam int EV_RX_ERR   = 4;
   localparam int NEV         = 5;
   localparam logic [2:0]       ADDR_FIXED = 3'h3;
   localparam logic [OFS_W-1:0] OFS_ZERO   = 13'h0000;
   localparam logic [OFS_W-1:0] OFS_ONE    = 13'h0001;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_WAIT = 2'b01,
      TX_SEND = 2'b10
   } tx_state_e;
endpackage

// >>> design/serial_dual_buffer_dma.sv
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
module serial_dual_buffer_dma #(
   parameter int OFS_BITS = 13
) (
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire logic                          cyc_i,
   input  wire logic                          stb_i,
   input  wire logic                          we_i,
   input  wire logic [31:0]                   adr_i,
   input  wire logic [3:0]                    sel_i,
   input  wire logic [31:0]                   dat_i,
   output logic      [31:0]                   dat_o,
   output logic                               ack_o,
   output logic                               irq_o,
   input  wire logic                          rx_valid_i,
   input  wire logic [7:0]                    rx_data_i,
   input  wire logic                          rx_err_i,
   output logic                               rx_ready_o,
   output logic                               ram_wr_o,
   output logic      [serial_dma_pkg::OFS_W-1:0] ram_wr_addr_o,
   output logic      [7:0]                    ram_wr_data_o,
   output logic                               ram_rd_o,
   output logic      [serial_dma_pkg::OFS_W-1:0] ram_rd_addr_o,
   input  wire logic [7:0]                    ram_rd_data_i,
   output logic                               tx_valid_o,
   output logic      [7:0]                    tx_data_o,
   input  wire logic                          tx_ready_i
);
   import serial_dma_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic [OFS_W-1:0] start_r [NBUF];
   logic [OFS_W-1:0] end_r   [NBUF];
   logic [NBUF-1:0]  load_r;
   logic [OFS_W-1:0] cnt_a_r, cnt_b_r, tx_cnt_r, err_a_r, err_b_r;
   logic             seen_a_r, seen_b_r, rx_sel_r, tx_sel_r, ack_r;
   logic [NEV-1:0]   irq_stat_r, irq_mask_r, ev;
   logic [REG_W-1:0] rd_word;
   logic [IDX_W-1:0] idx;
   logic             hit, req_new, wr_go, rd_go, rx_rst, tx_rst;
   logic             rx_act_a, rx_act_b, rx_take, rx_last, tx_act_a, tx_act_b;
   logic             tx_done, tx_last, rearm_a, rearm_b;
   logic [OFS_W-1:0] rx_addr, tx_addr;
   tx_state_e        tx_state_r;

   function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old,
                                                 input logic [REG_W-1:0] nw,
                                                 input logic [1:0]       be);
      merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
   endfunction

   function automatic logic [REG_W-1:0] addr_word(input logic [OFS_W-1:0] v);
      addr_word = {1'b0, ADDR_FIXED[1:0], v};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: the answer comes one cycle after the request is seen.
   assign idx     = adr_i[IDX_W+1:2];
   assign hit     = (adr_i[31:IDX_W+2] == '0) && (adr_i[1:0] == 2'b00);
   assign req_new = cyc_i && stb_i && !ack_r;
   assign wr_go   = cyc_i && stb_i && ack_r && we_i && hit;
   assign rd_go   = cyc_i && stb_i && ack_r && !we_i && hit;
   assign ack_o   = ack_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req_new;
      end
   end

   always_comb begin
      rd_word = '0;
      case (idx)
         IDX_RX_A_START: rd_word = addr_word(start_r[BUF_RX_A]);
         IDX_RX_A_END:   rd_word = addr_word(end_r[BUF_RX_A]);
         IDX_RX_B_START: rd_word = addr_word(start_r[BUF_RX_B]);
         IDX_RX_B_END:   rd_word = addr_word(end_r[BUF_RX_B]);
         IDX_TX_A_START: rd_word = addr_word(start_r[BUF_TX_A]);
         IDX_TX_A_END:   rd_word = addr_word(end_r[BUF_TX_A]);
         IDX_TX_B_START: rd_word = addr_word(start_r[BUF_TX_B]);
         IDX_TX_B_END:   rd_word = addr_word(end_r[BUF_TX_B]);
         IDX_RX_A_FILL:  rd_word = {3'h0, cnt_a_r};
         IDX_RX_B_FILL:  rd_word = {3'h0, cnt_b_r};
         IDX_TX_OFS:     rd_word = {3'h0, tx_cnt_r};
         IDX_STATUS:     rd_word = {12'h000, tx_act_b, tx_act_a, rx_act_b, rx_act_a};
         IDX_RX_A_ERR:   rd_word = {3'h0, err_a_r};
         IDX_RX_B_ERR:   rd_word = {3'h0, err_b_r};
         IDX_CTRL:       rd_word = {12'h000, load_r};
         IDX_IRQ_STAT:   rd_word = {11'h000, irq_stat_r};
         IDX_IRQ_MASK:   rd_word = {11'h000, irq_mask_r};
         default:        rd_word = '0;
      endcase
      if (!hit) begin
         rd_word = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= '0;
      end else if (req_new) begin
         dat_o <= {16'h0000, rd_word};
      end
   end

   // Start and end addresses; only the 13-bit field is stored.
   for (genvar g = 0; g < NBUF; g++) begin : g_addr
      localparam logic [IDX_W-1:0] IDX_S = IDX_RX_A_START + IDX_W'(4 * g);
      logic [REG_W-1:0] nw_s, nw_e;
      assign nw_s = merge16(addr_word(start_r[g]), dat_i[15:0], sel_i[1:0]);
      assign nw_e = merge16(addr_word(end_r[g]), dat_i[15:0], sel_i[1:0]);
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            start_r[g] <= OFS_ZERO;
            end_r[g]   <= OFS_ZERO;
         end else if (wr_go && idx == IDX_S) begin
            start_r[g] <= nw_s[OFS_W-1:0];
         end else if (wr_go && idx == IDX_S + IDX_W'(2)) begin
            end_r[g] <= nw_e[OFS_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control: ones load buffers, zeros do nothing; reset bits self-clear.
   assign rx_rst  = wr_go && idx == IDX_CTRL && sel_i[0] && dat_i[CTRL_RX_RST];
   assign tx_rst  = wr_go && idx == IDX_CTRL && sel_i[0] && dat_i[CTRL_TX_RST];
   assign rearm_a = rx_rst || (wr_go && idx == IDX_CTRL && sel_i[0]
                               && dat_i[BUF_RX_A] && !load_r[BUF_RX_A]);
   assign rearm_b = rx_rst || (wr_go && idx == IDX_CTRL && sel_i[0]
                               && dat_i[BUF_RX_B] && !load_r[BUF_RX_B]);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         load_r <= '0;
      end else begin
         if (wr_go && idx == IDX_CTRL && sel_i[0]) begin
            load_r <= load_r | dat_i[NBUF-1:0];
         end
         if (rx_take && rx_last) begin
            load_r[rx_sel_r ? BUF_RX_B : BUF_RX_A] <= 1'b0;
         end
         if (tx_done && tx_last) begin
            load_r[tx_sel_r ? BUF_TX_B : BUF_TX_A] <= 1'b0;
         end
         if (rx_rst) begin
            load_r[BUF_RX_B:BUF_RX_A] <= 2'b00;
         end
         if (tx_rst) begin
            load_r[BUF_TX_B:BUF_TX_A] <= 2'b00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive path: a selector points at the buffer in use and swaps on its
   // last byte, or when the current one is gone and its partner is loaded.
   assign rx_act_a   = load_r[BUF_RX_A] && !rx_sel_r;
   assign rx_act_b   = load_r[BUF_RX_B] && rx_sel_r;
   assign rx_ready_o = rx_act_a || rx_act_b;
   assign rx_take    = rx_valid_i && rx_ready_o;
   assign rx_addr    = rx_sel_r ? start_r[BUF_RX_B] + cnt_b_r : start_r[BUF_RX_A] + cnt_a_r;
   assign rx_last    = rx_addr == (rx_sel_r ? end_r[BUF_RX_B] : end_r[BUF_RX_A]);

   always_ff @(posedge clk_i) begin
      if (rst_i || rx_rst) begin
         rx_sel_r <= 1'b0;
      end else if (rx_take && rx_last) begin
         rx_sel_r <= !rx_sel_r;
      end else if (!load_r[rx_sel_r ? BUF_RX_B : BUF_RX_A]
                   && load_r[rx_sel_r ? BUF_RX_A : BUF_RX_B]) begin
         rx_sel_r <= !rx_sel_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || rx_rst) begin
         cnt_a_r <= OFS_ZERO;
         cnt_b_r <= OFS_ZERO;
      end else if (rx_take && !rx_sel_r) begin
         cnt_a_r <= rx_last ? OFS_ZERO : cnt_a_r + OFS_ONE;
      end else if (rx_take && rx_sel_r) begin
         cnt_b_r <= rx_last ? OFS_ZERO : cnt_b_r + OFS_ONE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ram_wr_o      <= 1'b0;
         ram_wr_addr_o <= OFS_ZERO;
         ram_wr_data_o <= 8'h00;
      end else begin
         ram_wr_o <= rx_take;
         if (rx_take) begin
            ram_wr_addr_o <= rx_addr;
            ram_wr_data_o <= rx_data_i;
         end
      end
   end

   // Clearing on rearm means offset zero reads the same with or without
   // an error there; the error event bit tells the two apart.
   always_ff @(posedge clk_i) begin
      if (rst_i || rearm_a) begin
         seen_a_r <= 1'b0;
         err_a_r  <= OFS_ZERO;
      end else if (rx_take && !rx_sel_r && rx_err_i && !seen_a_r) begin
         seen_a_r <= 1'b1;
         err_a_r  <= cnt_a_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || rearm_b) begin
         seen_b_r <= 1'b0;
         err_b_r  <= OFS_ZERO;
      end else if (rx_take && rx_sel_r && rx_err_i && !seen_b_r) begin
         seen_b_r <= 1'b1;
         err_b_r  <= cnt_b_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit path: fetch a byte, offer it, step on acceptance.
   assign tx_act_a = load_r[BUF_TX_A] && !tx_sel_r;
   assign tx_act_b = load_r[BUF_TX_B] && tx_sel_r;
   assign tx_addr  = tx_sel_r ? start_r[BUF_TX_B] + tx_cnt_r : start_r[BUF_TX_A] + tx_cnt_r;
   assign tx_last  = tx_addr == (tx_sel_r ? end_r[BUF_TX_B] : end_r[BUF_TX_A]);
   assign tx_done  = tx_state_r == TX_SEND && tx_ready_i;
   assign ram_rd_addr_o = tx_addr;

   always_ff @(posedge clk_i) begin
      if (rst_i || tx_rst) begin
         tx_state_r <= TX_IDLE;
         ram_rd_o   <= 1'b0;
         tx_valid_o <= 1'b0;
         tx_data_o  <= 8'h00;
      end else begin
         ram_rd_o <= 1'b0;
         case (tx_state_r)
            TX_IDLE: begin
               if (tx_act_a || tx_act_b) begin
                  ram_rd_o   <= 1'b1;
                  tx_state_r <= TX_WAIT;
               end
            end
            TX_WAIT: begin
               tx_state_r <= TX_SEND;
            end
            TX_SEND: begin
               if (!tx_valid_o) begin
                  tx_valid_o <= 1'b1;
                  tx_data_o  <= ram_rd_data_i;
               end else if (tx_ready_i) begin
                  tx_valid_o <= 1'b0;
                  tx_state_r <= TX_IDLE;
               end
            end
            default: begin
               tx_state_r <= TX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || tx_rst) begin
         tx_cnt_r <= OFS_ZERO;
         tx_sel_r <= 1'b0;
      end else if (tx_done && tx_valid_o) begin
         tx_cnt_r <= tx_last ? OFS_ZERO : tx_cnt_r + OFS_ONE;
         tx_sel_r <= tx_last ? !tx_sel_r : tx_sel_r;
      end else if (tx_state_r == TX_IDLE && !load_r[tx_sel_r ? BUF_TX_B : BUF_TX_A]
                   && load_r[tx_sel_r ? BUF_TX_A : BUF_TX_B]) begin
         tx_sel_r <= !tx_sel_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: a read clears only the bits it returned, so an event in the
   // cycle between capture and clear survives.
   assign ev[BUF_RX_A]  = rx_take && rx_last && !rx_sel_r;
   assign ev[BUF_RX_B]  = rx_take && rx_last && rx_sel_r;
   assign ev[BUF_TX_A]  = tx_done && tx_valid_o && tx_last && !tx_sel_r;
   assign ev[BUF_TX_B]  = tx_done && tx_valid_o && tx_last && tx_sel_r;
   assign ev[EV_RX_ERR] = rx_take && rx_err_i && (rx_sel_r ? !seen_b_r : !seen_a_r);
   assign irq_o         = |(irq_stat_r & irq_mask_r);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_r <= '0;
      end else if (rd_go && idx == IDX_IRQ_STAT) begin
         irq_stat_r <= (irq_stat_r & ~dat_o[NEV-1:0]) | ev;
      end else begin
         irq_stat_r <= irq_stat_r | ev;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_r <= '0;
      end else if (wr_go && idx == IDX_IRQ_MASK && sel_i[0]) begin
         irq_mask_r <= dat_i[NEV-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_take_a_mid;
      rx_take && !rx_sel_r && !rx_last && !rx_rst;
   endsequence
   sequence s_take_b_end;
      rx_take && rx_sel_r && rx_last && !rx_rst;
   endsequence
   sequence s_status_read;
      req_new && !we_i && hit && idx == IDX_STATUS;
   endsequence

   chk_rxa_offset_step: assert property (@(posedge clk_i) disable iff (rst_i)
      s_take_a_mid |=> cnt_a_r == $past(cnt_a_r) + OFS_ONE)
      else $error("receive A offset did not step by one");
   chk_rxb_offset_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
      s_take_b_end |=> cnt_b_r == OFS_ZERO && !load_r[BUF_RX_B])
      else $error("receive B offset did not wrap at end");
   chk_tx_offset_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_done && tx_valid_o && tx_last && !tx_rst |=> tx_cnt_r == OFS_ZERO)
      else $error("transmit offset did not wrap at end");
   chk_erra_first_capture: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_take && !rx_sel_r && rx_err_i && !seen_a_r && !rearm_a
      |=> err_a_r == $past(cnt_a_r) && seen_a_r)
      else $error("receive A first error offset not captured");
   chk_errb_first_capture: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_take && rx_sel_r && rx_err_i && !seen_b_r && !rearm_b
      |=> err_b_r == $past(cnt_b_r) && seen_b_r)
      else $error("receive B first error offset not captured");
   chk_err_offset_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      seen_a_r && !rearm_a |=> $stable(err_a_r))
      else $error("receive A error offset changed after capture");
   chk_err_rearm_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      rearm_b |=> !seen_b_r && err_b_r == OFS_ZERO)
      else $error("receive B error capture not rearmed");
   chk_status_active_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_status_read |=> dat_o[BUF_RX_A] == $past(rx_act_a) && ack_o)
      else $error("status active bit disagrees with receive A");
   chk_rx_swap_partner: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_take && rx_last && !rx_sel_r && load_r[BUF_RX_B] && !rx_rst |=> rx_act_b)
      else $error("receive did not switch to loaded buffer B");
   chk_addr_fixed_bits: assert property (@(posedge clk_i) disable iff (rst_i)
      req_new && !we_i && hit && idx == IDX_TX_B_END |=> dat_o[15:13] == ADDR_FIXED)
      else $error("address register top bits read wrong");
endmodule

// >>> tb/serial_dual_buffer_dma_bench.sv
`timescale 1ns/1ps
module serial_dual_buffer_dma_bench;
   import serial_dma_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i = 1'b0;
   logic [31:0] adr_i = 32'h0;
   logic [3:0]  sel_i = 4'h3;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        irq_o;
   logic        rx_valid_i = 1'b0;
   logic [7:0]  rx_data_i = 8'h00;
   logic        rx_err_i = 1'b0;
   logic        rx_ready_o;
   logic        ram_wr_o;
   logic [12:0] ram_wr_addr_o;
   logic [7:0]  ram_wr_data_o;
   logic        ram_rd_o;
   logic [12:0] ram_rd_addr_o;
   logic [7:0]  ram_rd_data_i;
   logic        tx_valid_o;
   logic [7:0]  tx_data_o;
   logic        tx_ready_i;
   int          fails = 0;
   int          checks = 0;
   int          cycles = 0;
   serial_dual_buffer_dma i_serial_dual_buffer_dma (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .rx_valid_i(rx_valid_i),
      .rx_data_i(rx_data_i), .rx_err_i(rx_err_i), .rx_ready_o(rx_ready_o),
      .ram_wr_o(ram_wr_o), .ram_wr_addr_o(ram_wr_addr_o), .ram_wr_data_o(ram_wr_data_o),
      .ram_rd_o(ram_rd_o), .ram_rd_addr_o(ram_rd_addr_o), .ram_rd_data_i(ram_rd_data_i),
      .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i));
   serial_far_side i_serial_far_side (.clk_i(clk_i), .rst_i(rst_i), .ram_wr_i(ram_wr_o),
      .ram_wr_addr_i(ram_wr_addr_o), .ram_wr_data_i(ram_wr_data_o), .ram_rd_i(ram_rd_o),
      .ram_rd_addr_i(ram_rd_addr_o), .ram_rd_data_o(ram_rd_data_i), .tx_valid_i(tx_valid_o),
      .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Generous against a run of roughly two hundred cycles.
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails = fails + 1;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic [15:0] idx, input logic w, input logic [15:0] wd,
                     output logic [15:0] rd);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {14'h0, idx, 2'b00};
      dat_i <= {16'h0, wd};
      // No local limit: a slave that never answers is caught by the cycle ceiling.
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o[15:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] idx, input logic [15:0] wd);
      logic [15:0] d;
      wb(idx, 1'b1, wd, d);
   endtask
   task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
      logic [15:0] d;
      wb(idx, 1'b0, 16'h0, d);
      chk(d, exp);
   endtask
   // Holds valid up between bytes; the caller drops it after the last one.
   task automatic rx(input logic [7:0] d, input logic e);
      rx_valid_i <= 1'b1;
      rx_data_i <= d;
      rx_err_i <= e;
      do @(posedge clk_i); while (rx_ready_o !== 1'b1);
   endtask
   task automatic wait_tx(input int k);
      while (i_serial_far_side.n_got < k) begin
         @(posedge clk_i);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(IDX_RX_A_START, 16'h6000);
      rd(IDX_RX_A_FILL, 16'h0000);
      rd(IDX_RX_B_ERR, 16'h0000);
      rd(IDX_STATUS, 16'h0000);
      wr(IDX_TX_B_END, 16'hffff);
      rd(IDX_TX_B_END, 16'h7fff);
      wr(IDX_RX_A_FILL, 16'hffff);
      rd(IDX_RX_A_FILL, 16'h0000);
      rd(16'h4418, 16'h0000);
      $display("registers done");
      wr(IDX_RX_A_START, 16'h0100);
      wr(IDX_RX_A_END, 16'h0103);
      wr(IDX_RX_B_START, 16'h0200);
      wr(IDX_RX_B_END, 16'h0201);
      wr(IDX_CTRL, 16'h0003);
      rd(IDX_STATUS, 16'h0001);
      @(posedge clk_i);
      rx(8'h11, 1'b0);
      rx(8'h22, 1'b1);
      rx_valid_i <= 1'b0;
      rd(IDX_RX_A_FILL, 16'h0002);
      rd(IDX_RX_A_ERR, 16'h0001);
      @(posedge clk_i);
      rx(8'h33, 1'b1);
      rx(8'h44, 1'b0);
      rx(8'h55, 1'b0);
      rx_valid_i <= 1'b0;
      rd(IDX_RX_A_ERR, 16'h0001);
      rd(IDX_RX_A_FILL, 16'h0000);
      rd(IDX_RX_B_FILL, 16'h0001);
      rd(IDX_STATUS, 16'h0002);
      @(posedge clk_i);
      rx(8'h66, 1'b1);
      rx_valid_i <= 1'b0;
      rd(IDX_RX_B_FILL, 16'h0000);
      rd(IDX_RX_B_ERR, 16'h0001);
      rd(IDX_STATUS, 16'h0000);
      chk({8'h0, i_serial_far_side.mem[13'h103]}, 16'h0044);
      chk({8'h0, i_serial_far_side.mem[13'h200]}, 16'h0055);
      chk({15'h0, irq_o}, 16'h0000);
      wr(IDX_IRQ_MASK, 16'h0001);
      // The mask lands on the ack edge, so look one edge later.
      @(posedge clk_i);
      chk({15'h0, irq_o}, 16'h0001);
      rd(IDX_IRQ_STAT, 16'h0013);
      rd(IDX_IRQ_STAT, 16'h0000);
      chk({15'h0, irq_o}, 16'h0000);
      wr(IDX_CTRL, 16'h0001);
      rd(IDX_RX_A_ERR, 16'h0000);
      wr(IDX_CTRL, 16'h0010);
      rd(IDX_RX_B_ERR, 16'h0000);
      $display("receive done");
      wr(IDX_TX_A_START, 16'h0100);
      wr(IDX_TX_A_END, 16'h0101);
      wr(IDX_TX_B_START, 16'h0200);
      wr(IDX_TX_B_END, 16'h0200);
      wr(IDX_IRQ_MASK, 16'h0008);
      wr(IDX_CTRL, 16'h000c);
      wait_tx(1);
      rd(IDX_TX_OFS, 16'h0001);
      rd(IDX_STATUS, 16'h0004);
      wait_tx(3);
      repeat (3) @(posedge clk_i);
      chk({8'h0, i_serial_far_side.got[0]}, 16'h0011);
      chk({8'h0, i_serial_far_side.got[1]}, 16'h0022);
      chk({8'h0, i_serial_far_side.got[2]}, 16'h0055);
      rd(IDX_TX_OFS, 16'h0000);
      rd(IDX_STATUS, 16'h0000);
      chk({15'h0, irq_o}, 16'h0001);
      rd(IDX_IRQ_STAT, 16'h000c);
      $display("transmit done");
      tally_and_finish();
   end
endmodule

// >>> tb/serial_far_side.sv
`timescale 1ns/1ps
module serial_far_side #(
   parameter int STALL = 20
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ram_wr_i,
   input  wire logic [12:0] ram_wr_addr_i,
   input  wire logic [7:0]  ram_wr_data_i,
   input  wire logic        ram_rd_i,
   input  wire logic [12:0] ram_rd_addr_i,
   output logic      [7:0]  ram_rd_data_o,
   input  wire logic        tx_valid_i,
   input  wire logic [7:0]  tx_data_i,
   output logic             tx_ready_o
);
   logic [7:0] mem [0:8191];
   logic [1:0] rd_win;
   logic [7:0] junk = 8'h5a;
   logic [7:0] got [0:7];
   int         wait_cnt;
   int         n_got;
   // Read data is shown only in the two cycles after a fetch; otherwise the lines toggle,
   // so a design that samples late sees garbage instead of a lucky stale byte.
   assign ram_rd_data_o = (rd_win != 2'h0) ? mem[ram_rd_addr_i] : junk;
   assign tx_ready_o = tx_valid_i && (wait_cnt >= STALL);
   always @(posedge clk_i) begin
      junk <= ~junk;
      if (rst_i) begin
         rd_win <= 2'h0;
         wait_cnt <= 0;
         n_got <= 0;
      end else begin
         rd_win <= {rd_win[0], ram_rd_i};
         if (ram_wr_i) mem[ram_wr_addr_i] <= ram_wr_data_i;
         if (tx_valid_i && tx_ready_o) begin
            got[n_got[2:0]] <= tx_data_i;
            n_got <= n_got + 1;
            wait_cnt <= 0;
         end else if (tx_valid_i) begin
            wait_cnt <= wait_cnt + 1;
         end
      end
   end
endmodule
